// >>> verilog/mace_regs.svh
`ifndef MACE_REGS_SVH
`define MACE_REGS_SVH

// Register addresses on the special function register bus
`define MACE_ADDR_B_HIGH 8'h92
`define MACE_ADDR_B_LOW 8'h91
`define MACE_ADDR_ACC0 8'h93
`define MACE_ADDR_ACC1 8'h94
`define MACE_ADDR_ACC2 8'h95
`define MACE_ADDR_ACC3 8'h96
`define MACE_ADDR_TOP 8'h97
`define MACE_ADDR_STATUS 8'hC0
`define MACE_ADDR_A_LOW 8'hC1
`define MACE_ADDR_A_HIGH 8'hC2
`define MACE_ADDR_CONFIG 8'hC3
`define MACE_ADDR_RND_LOW 8'hCE
`define MACE_ADDR_RND_HIGH 8'hCF

// Configuration fields
`define MACE_CFG_SHIFT_GO 5
`define MACE_CFG_SHIFT_DIR 4
`define MACE_CFG_CLEAR 3
`define MACE_CFG_SATURATE 2
`define MACE_CFG_FRACTIONAL 1
`define MACE_CFG_MULT_ONLY 0
`define MACE_CFG_WIDTH 6

// Status fields
`define MACE_STA_HARD_OVF 3
`define MACE_STA_ZERO 2
`define MACE_STA_SOFT_OVF 1
`define MACE_STA_NEGATIVE 0
`define MACE_STA_WIDTH 4

// Reset values
`define MACE_CFG_RESET 6'h00
`define MACE_STA_RESET 4'h4
`define MACE_STA_CLEARED 4'h0
`define MACE_BYTE_RESET 8'h00
`define MACE_ACC_RESET 40'h00_0000_0000
`define MACE_RND_RESET 16'h0000

// Data constants
`define MACE_TOP_POS_MAX 8'h7F
`define MACE_TOP_NEG_MIN 8'h80
`define MACE_RND_HALF 16'h8000
`define MACE_SAT_POS 16'h7FFF
`define MACE_SAT_NEG 16'h8000
`define MACE_ACC_BYTES 5

`endif

// >>> verilog/mace_pkg.sv
package mace_pkg;

   typedef struct packed {
      logic shift_go;
      logic shift_direction;
      logic clear_accumulator;
      logic saturate_enable;
      logic fractional_select;
      logic multiply_only_select;
   } mace_cfg_t;

   typedef struct packed {
      logic hard_overflow_flag;
      logic zero_flag;
      logic soft_overflow_flag;
      logic negative_flag;
   } mace_sta_t;

   typedef logic [39:0] mace_acc_t;
   typedef logic [15:0] mace_word_t;

endpackage : mace_pkg

// >>> verilog/mace_rnd_if.sv
`timescale 1ns/100ps
interface mace_rnd_if;
   mace_pkg::mace_acc_t acc;
   logic sat_en;
   logic go;
   mace_pkg::mace_word_t rnd;

   modport eng (output acc, output sat_en, output go, input rnd);
   modport rnd_side (input acc, input sat_en, input go, output rnd);
endinterface : mace_rnd_if

// >>> verilog/mace_round.sv
`timescale 1ns/100ps
`include "mace_regs.svh"
module mace_round (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Engine side
   mace_rnd_if.rnd_side bus
);

   logic [15:0] hi;
   logic [15:0] lo;
   logic inc;
   logic [16:0] sum;
   logic soft_ovf;
   logic rnd_ovf;
   logic [15:0] sat_val;
   logic [15:0] rnd_d;
   logic [15:0] rnd_q;

   assign hi = bus.acc[31:16];
   assign lo = bus.acc[15:0];
   // Unbiased: ties go to the even neighbour
   assign inc = (lo > `MACE_RND_HALF) |
                ((lo == `MACE_RND_HALF) & hi[0]);
   assign sum = {hi[15], hi} + {16'h0000, inc};
   assign soft_ovf = ~((&bus.acc[39:31]) | ~(|bus.acc[39:31]));
   // An increment past 0x7FFF also overflows the rounded word
   assign rnd_ovf = soft_ovf | (~bus.acc[39] & (sum[16] ^ sum[15]));
   assign sat_val = bus.acc[39] ? `MACE_SAT_NEG : `MACE_SAT_POS;
   assign rnd_d = (bus.sat_en & rnd_ovf) ? sat_val : sum[15:0];

   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
         rnd_q <= `MACE_RND_RESET;
      else if (bus.go)
         rnd_q <= rnd_d;
   end

   assign bus.rnd = rnd_q;

endmodule : mace_round

// >>> verilog/mace_engine.sv
`timescale 1ns/100ps
`include "mace_regs.svh"
module mace_engine (
   // Clock and reset
   input wire logic MCLK_I,
   input wire logic RST_B_I,
   // Special function register bus
   input wire logic [7:0] SFR_ADDR_I,
   input wire logic [7:0] SFR_WDATA_I,
   input wire logic SFR_WR_I,
   input wire logic SFR_RD_I,
   output logic [7:0] SFR_RDATA_O
);

   localparam logic [7:0] ACC_ADDR [`MACE_ACC_BYTES] = '{
      `MACE_ADDR_ACC0, `MACE_ADDR_ACC1, `MACE_ADDR_ACC2,
      `MACE_ADDR_ACC3, `MACE_ADDR_TOP};

   mace_pkg::mace_cfg_t cfg_q;
   mace_pkg::mace_cfg_t cfg_d;
   mace_pkg::mace_sta_t sta_q;
   mace_pkg::mace_sta_t sta_d;
   logic [7:0] a_hi_q;
   logic [7:0] a_lo_q;
   logic [7:0] b_hi_q;
   logic [7:0] b_lo_q;
   mace_pkg::mace_acc_t acc_q;
   mace_pkg::mace_acc_t acc_d;
   mace_pkg::mace_acc_t prod_q;
   mace_pkg::mace_acc_t prod_d;
   mace_pkg::mace_acc_t acc_sw;
   mace_pkg::mace_acc_t acc_op;
   mace_pkg::mace_acc_t acc_shift;
   logic s1_q;
   logic s2_q;
   logic ms_q;
   logic rgo_q;
   logic rgo_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;

   logic wr_cfg;
   logic wr_sta;
   logic wr_a_hi;
   logic wr_a_lo;
   logic wr_b_hi;
   logic wr_b_lo;
   logic [`MACE_ACC_BYTES-1:0] wr_acc;
   logic wr_acc0;
   logic signed [31:0] prod_raw;
   logic ho_set;
   logic op_soft;

   mace_rnd_if rnd_bus ();

   // Write decode
   assign wr_cfg = SFR_WR_I & (SFR_ADDR_I == `MACE_ADDR_CONFIG);
   assign wr_sta = SFR_WR_I & (SFR_ADDR_I == `MACE_ADDR_STATUS);
   assign wr_a_hi = SFR_WR_I & (SFR_ADDR_I == `MACE_ADDR_A_HIGH);
   assign wr_a_lo = SFR_WR_I & (SFR_ADDR_I == `MACE_ADDR_A_LOW);
   assign wr_b_hi = SFR_WR_I & (SFR_ADDR_I == `MACE_ADDR_B_HIGH);
   assign wr_b_lo = SFR_WR_I & (SFR_ADDR_I == `MACE_ADDR_B_LOW);
   assign wr_acc0 = wr_acc[0];

   // Software byte writes into the accumulator
   genvar k;
   generate
      for (k = 0; k < `MACE_ACC_BYTES; k++)
      begin : g_acc_byte
         assign wr_acc[k] = SFR_WR_I & (SFR_ADDR_I == ACC_ADDR[k]);
         assign acc_sw[8*k+7:8*k] = wr_acc[k] ? SFR_WDATA_I :
                                    acc_q[8*k+7:8*k];
      end
   endgenerate

   // Stage one: signed multiply with optional fractional scaling
   assign prod_raw = $signed({a_hi_q, a_lo_q}) *
                     $signed({b_hi_q, b_lo_q});
   assign prod_d = cfg_q.fractional_select ?
                   {{7{prod_raw[31]}}, prod_raw, 1'b0} :
                   {{8{prod_raw[31]}}, prod_raw};

   // Stage two: add to accumulator, or add to zero when multiply only
   assign acc_op = ms_q ? prod_q : acc_q + prod_q;

   // Arithmetic shift by one bit
   assign acc_shift = cfg_q.shift_direction ?
                      {acc_q[39], acc_q[39:1]} :
                      {acc_q[38:0], 1'b0};

   // Top byte crossing the 0x7F/0x80 boundary, only when accumulating
   assign ho_set = s2_q & ~ms_q & ~cfg_q.clear_accumulator &
                   (((acc_q[39:32] == `MACE_TOP_POS_MAX) &
                     (acc_op[39:32] == `MACE_TOP_NEG_MIN)) |
                    ((acc_q[39:32] == `MACE_TOP_NEG_MIN) &
                     (acc_op[39:32] == `MACE_TOP_POS_MAX)));
   assign op_soft = ~((&acc_op[39:31]) | ~(|acc_op[39:31]));

   // Rounding follows an operation, a shift or a byte-0 write
   assign rgo_d = (s2_q | cfg_q.shift_go | wr_acc0) &
                  ~cfg_q.clear_accumulator;

   // Accumulator next value; clear outranks everything else
   always_comb
   begin
      if (cfg_q.clear_accumulator)
         acc_d = `MACE_ACC_RESET;
      else if (s2_q)
         acc_d = acc_op;
      else if (cfg_q.shift_go)
         acc_d = acc_shift;
      else
         acc_d = acc_sw;
   end

   // Configuration: a software write wins over the self-clear
   always_comb
   begin
      cfg_d = cfg_q;
      if (cfg_q.shift_go)
         cfg_d.shift_go = 1'b0;
      if (cfg_q.clear_accumulator)
         cfg_d.clear_accumulator = 1'b0;
      if (wr_cfg)
         cfg_d = SFR_WDATA_I[`MACE_CFG_WIDTH-1:0];
   end

   // Status: hardware updates win over a colliding software write
   always_comb
   begin
      sta_d = sta_q;
      if (wr_sta)
         sta_d = SFR_WDATA_I[`MACE_STA_WIDTH-1:0];
      if (cfg_q.clear_accumulator)
         sta_d = `MACE_STA_CLEARED;
      else if (s2_q)
      begin
         sta_d.zero_flag = (acc_op == `MACE_ACC_RESET);
         sta_d.soft_overflow_flag = op_soft;
         sta_d.negative_flag = acc_op[39];
         sta_d.hard_overflow_flag = sta_d.hard_overflow_flag |
                                    ho_set;
      end
   end

   // Read selection
   always_comb
   begin
      if (SFR_ADDR_I == `MACE_ADDR_CONFIG)
         rdata_d = {2'b00, cfg_q};
      else if (SFR_ADDR_I == `MACE_ADDR_STATUS)
         rdata_d = {4'h0, sta_q};
      else if (SFR_ADDR_I == `MACE_ADDR_A_HIGH)
         rdata_d = a_hi_q;
      else if (SFR_ADDR_I == `MACE_ADDR_A_LOW)
         rdata_d = a_lo_q;
      else if (SFR_ADDR_I == `MACE_ADDR_B_HIGH)
         rdata_d = b_hi_q;
      else if (SFR_ADDR_I == `MACE_ADDR_B_LOW)
         rdata_d = b_lo_q;
      else if (SFR_ADDR_I == `MACE_ADDR_ACC0)
         rdata_d = acc_q[7:0];
      else if (SFR_ADDR_I == `MACE_ADDR_ACC1)
         rdata_d = acc_q[15:8];
      else if (SFR_ADDR_I == `MACE_ADDR_ACC2)
         rdata_d = acc_q[23:16];
      else if (SFR_ADDR_I == `MACE_ADDR_ACC3)
         rdata_d = acc_q[31:24];
      else if (SFR_ADDR_I == `MACE_ADDR_TOP)
         rdata_d = acc_q[39:32];
      else if (SFR_ADDR_I == `MACE_ADDR_RND_HIGH)
         rdata_d = rnd_bus.rnd[15:8];
      else if (SFR_ADDR_I == `MACE_ADDR_RND_LOW)
         rdata_d = rnd_bus.rnd[7:0];
      else
         rdata_d = `MACE_BYTE_RESET;
   end

   // Kept apart so each register's priority lives in its own next value
   always_ff @(posedge MCLK_I)
   begin
      if (!RST_B_I)
         cfg_q <= `MACE_CFG_RESET;
      else
         cfg_q <= cfg_d;
   end

   always_ff @(posedge MCLK_I)
   begin
      if (!RST_B_I)
         sta_q <= `MACE_STA_RESET;
      else
         sta_q <= sta_d;
   end

   always_ff @(posedge MCLK_I)
   begin
      if (!RST_B_I)
         acc_q <= `MACE_ACC_RESET;
      else
         acc_q <= acc_d;
   end

   always_ff @(posedge MCLK_I)
   begin
      if (!RST_B_I)
      begin
         a_hi_q <= `MACE_BYTE_RESET;
         a_lo_q <= `MACE_BYTE_RESET;
         b_hi_q <= `MACE_BYTE_RESET;
         b_lo_q <= `MACE_BYTE_RESET;
      end
      else
      begin
         if (wr_a_hi)
            a_hi_q <= SFR_WDATA_I;
         if (wr_a_lo)
            a_lo_q <= SFR_WDATA_I;
         if (wr_b_hi)
            b_hi_q <= SFR_WDATA_I;
         if (wr_b_lo)
            b_lo_q <= SFR_WDATA_I;
      end
   end

   // Pipeline control; a new start may land while stage two runs
   always_ff @(posedge MCLK_I)
   begin
      if (!RST_B_I)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
      end
      else
      begin
         s1_q <= wr_b_lo;
         s2_q <= s1_q;
      end
   end

   // Mode is captured with the product so a later config write is harmless
   always_ff @(posedge MCLK_I)
   begin
      if (!RST_B_I)
      begin
         prod_q <= `MACE_ACC_RESET;
         ms_q <= 1'b0;
      end
      else if (s1_q)
      begin
         prod_q <= prod_d;
         ms_q <= cfg_q.multiply_only_select;
      end
   end

   // A clear in the same cycle cancels the rounding update
   always_ff @(posedge MCLK_I)
   begin
      if (!RST_B_I)
         rgo_q <= 1'b0;
      else
         rgo_q <= rgo_d;
   end

   always_ff @(posedge MCLK_I)
   begin
      if (!RST_B_I)
         rdata_q <= `MACE_BYTE_RESET;
      else if (SFR_RD_I)
         rdata_q <= rdata_d;
   end

   assign rnd_bus.acc = acc_q;
   assign rnd_bus.sat_en = cfg_q.saturate_enable;
   assign rnd_bus.go = rgo_q;

   mace_round u_round (
      .clk_i(MCLK_I),
      .rst_b_i(RST_B_I),
      .bus(rnd_bus)
   );

   assign SFR_RDATA_O = rdata_q;

endmodule : mace_engine

// >>> sim/mace_engine_props.sv
`timescale 1ns/100ps
`include "mace_regs.svh"
module mace_engine_props (
   // Clock and reset
   input wire logic MCLK_I,
   input wire logic RST_B_I,
   // Register bus
   input wire logic [7:0] SFR_ADDR_I,
   input wire logic [7:0] SFR_WDATA_I,
   input wire logic SFR_WR_I,
   input wire logic SFR_RD_I,
   input wire logic [7:0] SFR_RDATA_O
);
   default clocking cb @(posedge MCLK_I);
   endclocking
   default disable iff (!RST_B_I);
   wire rd_cfg = SFR_RD_I && !SFR_WR_I && SFR_ADDR_I == `MACE_ADDR_CONFIG;
   wire rd_sta = SFR_RD_I && !SFR_WR_I && SFR_ADDR_I == `MACE_ADDR_STATUS;
   wire rd_acc3 = SFR_RD_I && !SFR_WR_I && SFR_ADDR_I == `MACE_ADDR_ACC3;
   wire wr_cfg = SFR_WR_I && SFR_ADDR_I == `MACE_ADDR_CONFIG;
   wire wr_acc3 = SFR_WR_I && SFR_ADDR_I == `MACE_ADDR_ACC3;
   wire wr_blow = SFR_WR_I && SFR_ADDR_I == `MACE_ADDR_B_LOW;
   property p_cfg_top;
      rd_cfg |=> SFR_RDATA_O[7:6] == 2'h0;
   endproperty
   a_cfg_top: assert property (p_cfg_top)
      else $error("config top bits not zero");
   property p_sta_top;
      rd_sta |=> SFR_RDATA_O[7:4] == 4'h0;
   endproperty
   a_sta_top: assert property (p_sta_top)
      else $error("status top bits not zero");
   property p_shift_clr;
      (wr_cfg && SFR_WDATA_I[5]) ##1 !SFR_WR_I ##1 rd_cfg |=> !SFR_RDATA_O[5];
   endproperty
   a_shift_clr: assert property (p_shift_clr)
      else $error("shift bit not self cleared");
   property p_clear_bit;
      (wr_cfg && SFR_WDATA_I[3]) ##1 !SFR_WR_I ##1 rd_cfg |=> !SFR_RDATA_O[3];
   endproperty
   a_clear_bit: assert property (p_clear_bit)
      else $error("clear bit not self cleared");
   property p_clear_sta;
      (wr_cfg && SFR_WDATA_I[3]) ##1 !SFR_WR_I ##1 rd_sta
         |=> SFR_RDATA_O == 8'h00;
   endproperty
   a_clear_sta: assert property (p_clear_sta)
      else $error("status not reset by clear");
   property p_clear_acc;
      (wr_cfg && SFR_WDATA_I[3]) ##1 !SFR_WR_I ##1 rd_acc3
         |=> SFR_RDATA_O == 8'h00;
   endproperty
   a_clear_acc: assert property (p_clear_acc)
      else $error("accumulator not zeroed by clear");
   property p_acc3_map;
      !SFR_WR_I [*2] ##1 wr_acc3 ##1 rd_acc3
         |=> SFR_RDATA_O == $past(SFR_WDATA_I, 2);
   endproperty
   a_acc3_map: assert property (p_acc3_map)
      else $error("byte 3 readback differs");
   property p_ho_sticky;
      !SFR_WR_I ##1 rd_sta ##1 (rd_sta && SFR_RDATA_O[3]) |=> SFR_RDATA_O[3];
   endproperty
   a_ho_sticky: assert property (p_ho_sticky)
      else $error("hard overflow dropped by itself");
   c_start: cover property (wr_blow);
   c_shift: cover property (wr_cfg && SFR_WDATA_I[5]);
   c_clear: cover property (wr_cfg && SFR_WDATA_I[3]);
endmodule : mace_engine_props
bind mace_engine mace_engine_props u_props (.MCLK_I(MCLK_I),
   .RST_B_I(RST_B_I), .SFR_ADDR_I(SFR_ADDR_I), .SFR_WDATA_I(SFR_WDATA_I),
   .SFR_WR_I(SFR_WR_I), .SFR_RD_I(SFR_RD_I), .SFR_RDATA_O(SFR_RDATA_O));

// >>> sim/mace_cpu_model.sv
`timescale 1ns/100ps
module mace_cpu_model (
   // Clock
   input wire logic clk_i,
   // Register bus
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o,
   output logic wr_o,
   output logic rd_o,
   input wire logic [7:0] rdata_i
);
   initial
   begin
      addr_o = 8'h00;
      wdata_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
   end
   // Strobes stay up between back-to-back calls; one edge is one transfer
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr_o = a;
      wdata_o = d;
      rd_o = 1'b0;
      wr_o = 1'b1;
      @(posedge clk_i);
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      addr_o = a;
      wdata_o = ~wdata_o;
      wr_o = 1'b0;
      rd_o = 1'b1;
      @(posedge clk_i);
      #1;
      d = rdata_i;
   endtask : rd
   task automatic idle(input int n);
      wr_o = 1'b0;
      rd_o = 1'b0;
      addr_o = ~addr_o;
      repeat (n) @(posedge clk_i);
      #1;
   endtask : idle
   // Three quiet cycles keep software off the pipeline and let rounding land
   task automatic mac(input logic [15:0] a, input logic [15:0] b);
      wr(8'hC2, a[15:8]);
      wr(8'hC1, a[7:0]);
      wr(8'h92, b[15:8]);
      wr(8'h91, b[7:0]);
      idle(3);
   endtask : mac
endmodule : mace_cpu_model

// >>> sim/multiply_accumulate_engine_bench.sv
`timescale 1ns/100ps
module multiply_accumulate_engine_bench;
   logic mclk;
   logic rst_b;
   wire logic [7:0] addr;
   wire logic [7:0] wdata;
   wire logic wr;
   wire logic rd;
   wire logic [7:0] rdata;
   int n_mismatch = 0;
   int total_checks = 0;
   mace_engine uut (.MCLK_I(mclk), .RST_B_I(rst_b), .SFR_ADDR_I(addr),
      .SFR_WDATA_I(wdata), .SFR_WR_I(wr), .SFR_RD_I(rd), .SFR_RDATA_O(rdata));
   mace_cpu_model cpu (.clk_i(mclk), .addr_o(addr), .wdata_o(wdata),
      .wr_o(wr), .rd_o(rd), .rdata_i(rdata));
   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   task automatic close_out;
      if (n_mismatch == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : close_out
   task automatic chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] v;
      cpu.rd(a, v);
      total_checks++;
      if (v !== e)
      begin
         n_mismatch++;
         $display("wrong value reg %h exp %h got %h", a, e, v);
      end
   endtask : chk
   // Top byte first so the byte 0 write retriggers rounding last
   task automatic setacc(input logic [39:0] v);
      for (int i = 4; i >= 0; i--)
         cpu.wr(8'h93 + 8'(i), v[8*i +: 8]);
      cpu.idle(1);
   endtask : setacc
   // Other config bits written with the clear survive it
   task automatic clr(input logic [7:0] c, input logic [7:0] ra,
                      input logic [7:0] e);
      cpu.wr(8'hC3, c);
      cpu.idle(1);
      chk(ra, e);
   endtask : clr
   initial
   begin
      #100000;
      n_mismatch++;
      close_out;
   end
   initial
   begin
      rst_b = 1'b0;
      repeat (5) @(posedge mclk);
      #1;
      rst_b = 1'b1;
      chk(8'hC3, 8'h00);
      chk(8'hC0, 8'h04);
      chk(8'h92, 8'h00);
      chk(8'hC2, 8'h00);
      chk(8'h90, 8'h00);
      cpu.wr(8'hC3, 8'hC7);
      chk(8'hC3, 8'h07);
      cpu.wr(8'hC3, 8'h00);
      cpu.wr(8'hC0, 8'hF0);
      chk(8'hC0, 8'h00);
      cpu.idle(2);
      cpu.wr(8'h96, 8'h5A);
      chk(8'h96, 8'h5A);
      // Integer multiply-only replaces whatever the accumulator held
      cpu.wr(8'hC3, 8'h01);
      cpu.mac(16'h1234, 16'hFEDC);
      chk(8'h97, 8'hFF);
      chk(8'h96, 8'hFF);
      chk(8'h95, 8'hEB);
      chk(8'h94, 8'h3C);
      chk(8'h93, 8'hB0);
      chk(8'hC0, 8'h01);
      chk(8'hCF, 8'hFF);
      chk(8'hCE, 8'hEB);
      // Fractional accumulate to zero
      clr(8'h0A, 8'hC3, 8'h02);
      cpu.mac(16'h4000, 16'h2000);
      chk(8'h96, 8'h10);
      chk(8'hC0, 8'h00);
      cpu.mac(16'h4000, 16'hE000);
      chk(8'h96, 8'h00);
      chk(8'hC0, 8'h04);
      // Shifts: left once, then right twice back to back
      setacc(40'h40_8844_2211);
      cpu.wr(8'hC3, 8'h20);
      cpu.idle(1);
      chk(8'hC3, 8'h00);
      chk(8'h97, 8'h81);
      chk(8'h93, 8'h22);
      cpu.wr(8'hC3, 8'h30);
      cpu.wr(8'hC3, 8'h30);
      cpu.idle(1);
      chk(8'hC3, 8'h10);
      chk(8'h97, 8'hE0);
      chk(8'h93, 8'h08);
      chk(8'hC0, 8'h04);
      // Top byte crosses 0x7F to 0x80 while accumulating
      clr(8'h08, 8'h96, 8'h00);
      setacc(40'h7F_FFFF_FFFF);
      cpu.mac(16'h0001, 16'h0001);
      chk(8'hC0, 8'h0B);
      chk(8'hC0, 8'h0B);
      cpu.mac(16'h0000, 16'h0000);
      chk(8'hC0, 8'h0B);
      clr(8'h08, 8'hC0, 8'h00);
      // Rounding tie and saturation
      setacc(40'h00_0001_8000);
      chk(8'hCE, 8'h02);
      setacc(40'h00_8000_0000);
      chk(8'hCF, 8'h80);
      cpu.wr(8'hC3, 8'h04);
      cpu.wr(8'h93, 8'h00);
      cpu.idle(1);
      chk(8'hCF, 8'h7F);
      chk(8'hCE, 8'hFF);
      chk(8'h96, 8'h80);
      // Negative overflow, plain negative and an increment past 0x7FFF
      setacc(40'hFF_7FFF_0000);
      chk(8'hCF, 8'h80);
      chk(8'hCE, 8'h00);
      setacc(40'hFF_FFFF_0000);
      chk(8'hCF, 8'hFF);
      chk(8'hCE, 8'hFF);
      setacc(40'h00_7FFF_C000);
      chk(8'hCF, 8'h7F);
      chk(8'hCE, 8'hFF);
      // Top byte crosses 0x80 to 0x7F, then software drops the flag
      clr(8'h08, 8'hC0, 8'h00);
      setacc(40'h80_0000_0000);
      cpu.mac(16'hFFFF, 16'h0001);
      chk(8'hC0, 8'h0A);
      chk(8'h97, 8'h7F);
      cpu.wr(8'hC0, 8'h00);
      chk(8'hC0, 8'h00);
      close_out;
   end
endmodule : multiply_accumulate_engine_bench
